//--- src/dram_bank_tally.sv
// one bank's rolling activate tally
`timescale 1ns/100ps
module dram_bank_tally
  import dram_cmd_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // updates
  input wire logic i_inc,
  input wire logic i_dec,
  input wire logic [8:0] i_dec_amt,
  input wire logic [8:0] i_max,
  // state
  output logic [8:0] o_count,
  output logic o_at_max
);
  tally_s q, d;

  // one up per activate while below the maximum, down by the amount, never below zero
  always_comb begin
    d = q;
    if (i_inc && q.cnt < i_max) begin
      d.cnt = q.cnt + 9'h001;
    end else if (i_dec) begin
      d.cnt = (q.cnt > i_dec_amt) ? q.cnt - i_dec_amt : 9'h000;
    end
    d.at_max = (i_max != 9'h000) && (d.cnt >= i_max);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_count = q.cnt;
  assign o_at_max = q.at_max;
endmodule : dram_bank_tally

//--- src/dram_cmd_if.sv
// chip select and command/address bus between controller and device
`timescale 1ns/100ps
interface dram_cmd_if;
  logic cs;
  logic [5:0] ca;
  modport ctrl (output cs, output ca);
  modport dev (input cs, input ca);
endinterface : dram_cmd_if

//--- src/dram_cmd_map.svh
// constants for command framing and refresh management
`ifndef DRAM_CMD_MAP_SVH
`define DRAM_CMD_MAP_SVH
// first-edge opcodes on command/address lines 4..0 (line 5 carries a flag); the activate opcode uses lines 1..0 only
`define CA_MPC 5'h00
`define CA_PRE 5'h10
`define CA_REF 5'h08
`define CA_SRE 5'h18
`define CA_WR1 5'h04
`define CA_SRX 5'h14
`define CA_MWR1 5'h0C
`define CA_RD1 5'h02
`define CA_CAS2 5'h12
`define CA_MRW1 5'h06
`define CA_MRW2 5'h16
`define CA_MRR1 5'h0E
`define CA_ACT1 2'h1
`define CA_DES 6'h00
// mode register addresses
`define MR_MGMT_ADDR 6'h18
`define MR_DEC_ADDR 6'h24
// management mode register fields
`define MGMT_REQ_BIT 0
`define MGMT_IMT_LSB 1
`define MGMT_IMT_MSB 5
`define MGMT_MULT_LSB 6
`define MGMT_MULT_MSB 7
// decrement multiplier in half units, max threshold multiplier in whole units
`define DEC_HALF_0 4'h2
`define DEC_HALF_1 4'h3
`define DEC_HALF_2 4'h4
`define DEC_HALF_3 4'h8
`define MAXM_0 4'h2
`define MAXM_1 4'h4
`define MAXM_2 4'h6
`define MAXM_3 4'h8
// timing
`define CLK_PS 4000
`define T_ALL_BANK_MGMT_REFRESH_SMALL_NS 210
`define T_ALL_BANK_MGMT_REFRESH_LARGE_NS 280
`define T_PER_BANK_MGMT_REFRESH_SMALL_NS 170
`define T_PER_BANK_MGMT_REFRESH_LARGE_NS 190
`define NS2CYC(ns) ((((ns) * 1000) + `CLK_PS - 1) / `CLK_PS)
`define T_REFI_UNIT_NS 3906
`define REFI_UNIT_CYC ((`T_REFI_UNIT_NS * 1000) / `CLK_PS)
`define MPC_WAIT_CYC 2
`define NBANK 8
`define TALLY_W 9
`endif

//--- src/dram_cmd_pkg.sv
// types shared by both ends of the command link
package dram_cmd_pkg;
  typedef enum logic [3:0] {
    K_NONE, K_MPC, K_MPC_COL, K_PRE, K_REF, K_RFM, K_SRE, K_SRX,
    K_WR, K_MWR, K_RD, K_MRR, K_MRW, K_ACT, K_CAS2, K_MRW2
  } cmd_kind_e;
  typedef enum logic [2:0] {C_IDLE = 3'h1, C_SEND = 3'h2, C_WAIT = 3'h4} ctrl_state_e;
  typedef enum logic [1:0] {D_IDLE = 2'h1, D_SECOND = 2'h2} dev_state_e;
  typedef struct packed {
    logic [8:0] cnt;
    logic at_max;
  } tally_s;
  typedef struct packed {
    ctrl_state_e st;
    logic [3:0][6:0] seq;
    logic [1:0] left;
    logic [7:0] wait_cnt;
    logic cs;
    logic [5:0] ca;
    logic ready;
    logic refused;
    logic [9:0] sub;
    logic [4:0] unit;
    logic due;
    logic rfm_need;
    logic [7:0] blocked;
  } ctrl_s;
  typedef struct packed {
    dev_state_e st;
    logic [5:0] f_ca;
    cmd_kind_e f_kind;
    logic col_pend;
    cmd_kind_e c_kind;
    logic [2:0] c_ba;
    logic c_ap, c_bl, c_c9;
    logic act_pend;
    logic [9:0] a_hi;
    logic mrw_pend;
    logic m_op7;
    logic valid;
    cmd_kind_e kind;
    logic [2:0] bank;
    logic all, ap, b32;
    logic [9:0] col;
    logic [18:0] row;
    logic [5:0] mr_addr;
    logic [7:0] mr_op;
    logic [7:0] pre_mask;
    logic [1:0] dec_reg;
    logic [7:0] mgmt;
  } dev_s;
endpackage : dram_cmd_pkg

//--- src/dram_ctrl_end.sv
// controller end: frames commands and manages activate tallies
// ------------------------------------------------------------------
// Summary of operation
// - non-deselect commands take two cycles
// - bank select or all-banks flag picks banks
// - masked write uses burst 16, line5 low
// - auto-precharge flag closes bank after access
// - burst select 32/16, always driven defined
// - column bits 1:0 zero; writes drive 3:2 low
// - column first halves followed by column second
// - oscillator/calibration multi purpose: two deselects after
// - activate and mode write halves back to back
// - unused upper row bits driven high
// - device reports management need in bit 0
// - each activate adds one to bank tally
// - device exposes initial threshold in bits 5:1
// - refresh second half line 3 selects management
// - wait management cycle time after management refresh
// - management refresh lowers tally by threshold times multiplier
// - tally saturates at zero
// - no activate once tally reaches maximum
// - management refresh spaced like ordinary refresh
// - ordinary refresh lowers tally; interval bounded
// - self refresh leaves tallies unchanged
// ------------------------------------------------------------------
`timescale 1ns/100ps
`include "dram_cmd_map.svh"
module dram_ctrl_end
  import dram_cmd_pkg::*;
#(
  parameter bit LARGE_DENSITY = 1'b0,
  parameter bit USE_UPPER_ROW = 1'b0,
  parameter logic [7:0] REF_GAP_CYC = 8'h08,
  parameter logic [7:0] ROW_CYCLE_NS = 8'h3C
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // command request
  input wire logic i_req_valid,
  input wire cmd_kind_e i_req_kind,
  input wire logic [2:0] i_req_bank,
  input wire logic i_req_all,
  input wire logic i_req_ap,
  input wire logic i_req_bl32,
  input wire logic [9:0] i_req_col,
  input wire logic [18:0] i_req_row,
  input wire logic [5:0] i_req_mr_addr,
  input wire logic [7:0] i_req_op,
  output logic o_req_ready,
  output logic o_req_refused,
  // device mode register values
  input wire logic [7:0] i_mgmt_reg,
  input wire logic [1:0] i_dec_reg,
  input wire logic [4:0] i_refresh_rate_mult,
  // management status
  output logic [7:0] o_blocked,
  output logic o_refresh_due,
  output logic o_rfm_needed,
  // link
  dram_cmd_if.ctrl link
);
  // ----------------------------------------------------------------
  // tally arithmetic
  // ----------------------------------------------------------------
  localparam logic [7:0] RFM_AB_CYC = 8'(LARGE_DENSITY ?
    `NS2CYC(`T_ALL_BANK_MGMT_REFRESH_LARGE_NS) : `NS2CYC(`T_ALL_BANK_MGMT_REFRESH_SMALL_NS));
  localparam logic [7:0] RFM_PB_CYC = 8'(LARGE_DENSITY ?
    `NS2CYC(`T_PER_BANK_MGMT_REFRESH_LARGE_NS) : `NS2CYC(`T_PER_BANK_MGMT_REFRESH_SMALL_NS));

  ctrl_s q, d;
  logic [4:0] imt;
  logic [3:0] dec_half, max_mult;
  logic [8:0] imt_w, rfm_amt, max_val, dec_amt;
  logic [12:0] rfm_prod;
  logic [8:0] tally [`NBANK];
  logic [7:0] at_max, inc_hit, dec_hit, over_imt;
  logic req_bit, take, go, is_ref, is_rfm;

  // multipliers come from the device's read-only and writable fields
  always_comb begin
    imt = i_mgmt_reg[`MGMT_IMT_MSB:`MGMT_IMT_LSB];
    req_bit = i_mgmt_reg[`MGMT_REQ_BIT];
    case (i_dec_reg)
      2'h0: dec_half = `DEC_HALF_0;
      2'h1: dec_half = `DEC_HALF_1;
      2'h2: dec_half = `DEC_HALF_2;
      default: dec_half = `DEC_HALF_3;
    endcase
    case (i_mgmt_reg[`MGMT_MULT_MSB:`MGMT_MULT_LSB])
      2'h0: max_mult = `MAXM_0;
      2'h1: max_mult = `MAXM_1;
      2'h2: max_mult = `MAXM_2;
      default: max_mult = `MAXM_3;
    endcase
  end

  assign imt_w = {4'h0, imt};
  assign rfm_prod = {8'h00, imt} * {9'h000, dec_half};
  assign rfm_amt = rfm_prod[9:1];
  assign max_val = 9'({4'h0, imt} * {5'h00, max_mult});
  assign take = i_req_valid && q.ready;
  assign go = take && !(i_req_kind == K_ACT && at_max[i_req_bank]);
  assign is_ref = go && (i_req_kind == K_REF || (i_req_kind == K_RFM && !req_bit));
  assign is_rfm = go && i_req_kind == K_RFM && req_bit;
  assign dec_amt = is_rfm ? rfm_amt : imt_w;

  // ----------------------------------------------------------------
  // per-bank tallies; self refresh touches none of them
  // ----------------------------------------------------------------
  for (genvar b = 0; b < `NBANK; b++) begin : g_bank
    assign inc_hit[b] = go && i_req_kind == K_ACT && i_req_bank == 3'(b);
    assign dec_hit[b] = (is_ref || is_rfm) && (i_req_all || i_req_bank == 3'(b));
    assign over_imt[b] = tally[b] >= imt_w && imt_w != 9'h000;
    dram_bank_tally u_tally (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_inc(inc_hit[b]),
      .i_dec(dec_hit[b]),
      .i_dec_amt(dec_amt),
      .i_max(max_val),
      .o_count(tally[b]),
      .o_at_max(at_max[b])
    );
  end

  // ----------------------------------------------------------------
  // command word builder: up to four edges, then deselect wait
  // ----------------------------------------------------------------
  logic [3:0][6:0] w;
  logic [1:0] n;
  logic [7:0] wt, rfm_wt;
  logic [5:0] c2;
  logic bl, r17, r18;

  always_comb begin
    rfm_wt = i_req_all ? RFM_AB_CYC : RFM_PB_CYC;
    bl = (i_req_kind == K_MWR) ? 1'b0 : i_req_bl32;
    c2 = i_req_col[7:2];
    if (i_req_kind == K_WR || i_req_kind == K_MWR) begin
      c2[1:0] = 2'h0;
    end
    r17 = USE_UPPER_ROW ? i_req_row[17] : 1'b1;
    r18 = USE_UPPER_ROW ? i_req_row[18] : 1'b1;
    w = '0;
    n = 2'h1;
    wt = 8'h00;
    case (i_req_kind)
      K_WR, K_MWR, K_RD, K_MRR, K_MPC_COL: begin
        n = 2'h3;
        case (i_req_kind)
          K_WR: w[0] = {1'b1, bl, `CA_WR1};
          K_MWR: w[0] = {1'b1, 1'b0, `CA_MWR1};
          K_RD: w[0] = {1'b1, bl, `CA_RD1};
          K_MRR: w[0] = {1'b1, 1'b0, `CA_MRR1};
          default: w[0] = {1'b1, i_req_op[6], `CA_MPC};
        endcase
        if (i_req_kind == K_MRR) begin
          w[1] = {1'b0, i_req_mr_addr};
        end else if (i_req_kind == K_MPC_COL) begin
          w[1] = {1'b0, i_req_op[5:0]};
        end else begin
          w[1] = {1'b0, i_req_ap, i_req_col[9], 1'b0, i_req_bank};
        end
        w[2] = {1'b1, i_req_col[8], `CA_CAS2};
        w[3] = {1'b0, (i_req_kind == K_MRR) ? 6'h00 : c2};
      end
      K_MPC: begin
        w[0] = {1'b1, i_req_op[6], `CA_MPC};
        w[1] = {1'b0, i_req_op[5:0]};
        wt = 8'(`MPC_WAIT_CYC);
      end
      K_MRW: begin
        n = 2'h3;
        w[0] = {1'b1, i_req_op[7], `CA_MRW1};
        w[1] = {1'b0, i_req_mr_addr};
        w[2] = {1'b1, i_req_op[6], `CA_MRW2};
        w[3] = {1'b0, i_req_op[5:0]};
      end
      K_ACT: begin
        n = 2'h3;
        w[0] = {1'b1, i_req_row[15:12], `CA_ACT1};
        w[1] = {1'b0, i_req_row[11:10], i_req_row[16], i_req_bank};
        w[2] = {1'b1, i_req_row[9:6], r18, r17};
        w[3] = {1'b0, i_req_row[5:0]};
      end
      K_PRE: begin
        w[0] = {1'b1, i_req_all, `CA_PRE};
        w[1] = {1'b0, 3'h0, i_req_bank};
      end
      K_REF, K_RFM: begin
        w[0] = {1'b1, i_req_all, `CA_REF};
        w[1] = {1'b0, i_req_all, 1'b0, is_rfm, i_req_bank};
        // management refresh keeps the ordinary spacing as a floor
        wt = (is_rfm && rfm_wt > REF_GAP_CYC) ? rfm_wt : REF_GAP_CYC;
      end
      K_SRE: w[0] = {1'b1, 1'b0, `CA_SRE};
      K_SRX: w[0] = {1'b1, 1'b0, `CA_SRX};
      default: w[0] = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer, refresh interval timer, management flags
  // ----------------------------------------------------------------
  logic [16:0] refi_ns, rfmth_ns;
  logic unit_hit;

  assign refi_ns = 17'(i_refresh_rate_mult) * 17'(`T_REFI_UNIT_NS);
  assign rfmth_ns = 17'(imt) * 17'(ROW_CYCLE_NS);
  assign unit_hit = q.sub == 10'(`REFI_UNIT_CYC - 1);

  always_comb begin
    d = q;
    d.refused = take && !go;
    d.blocked = at_max;
    // only above the interval threshold does a high tally matter
    d.rfm_need = req_bit && (refi_ns > rfmth_ns) && (over_imt != 8'h00);
    case (q.st)
      C_IDLE: begin
        if (go) begin
          d.seq = {7'h00, w[3:1]};
          {d.cs, d.ca} = w[0];
          d.left = n; // words still to send after the first
          d.wait_cnt = wt;
          d.ready = 1'b0;
          d.st = C_SEND;
        end
      end
      C_SEND: begin
        {d.cs, d.ca} = q.seq[0]; // halves leave back to back
        d.seq = {7'h00, q.seq[3:1]};
        d.left = q.left - 2'h1;
        if (q.left == 2'h0) begin
          {d.cs, d.ca} = {1'b0, `CA_DES};
          d.ready = q.wait_cnt == 8'h00;
          d.st = d.ready ? C_IDLE : C_WAIT;
        end
      end
      C_WAIT: begin
        d.wait_cnt = q.wait_cnt - 8'h01;
        if (q.wait_cnt <= 8'h01) begin
          d.ready = 1'b1;
          d.st = C_IDLE;
        end
      end
      default: d.st = C_IDLE;
    endcase
    // interval counter restarts on each ordinary refresh; a due set wins
    d.sub = unit_hit ? 10'h000 : q.sub + 10'h001;
    d.unit = unit_hit ? q.unit + 5'h01 : q.unit;
    d.due = q.due && !(is_ref || is_rfm);
    if (is_ref) begin
      d.sub = 10'h000;
      d.unit = 5'h00;
    end
    if (unit_hit && i_refresh_rate_mult != 5'h00 && q.unit + 5'h01 >= i_refresh_rate_mult) begin
      d.due = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '{st: C_IDLE, ready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.cs = q.cs;
  assign link.ca = q.ca;
  assign o_req_ready = q.ready;
  assign o_req_refused = q.refused;
  assign o_blocked = q.blocked;
  assign o_refresh_due = q.due;
  assign o_rfm_needed = q.rfm_need;
endmodule : dram_ctrl_end

//--- src/dram_dev_end.sv
// device end: samples two-edge commands and decodes them
`timescale 1ns/100ps
`include "dram_cmd_map.svh"
module dram_dev_end
  import dram_cmd_pkg::*;
#(
  parameter bit MGMT_REQUIRED = 1'b1,
  parameter logic [4:0] INIT_THRESHOLD = 5'h10,
  parameter logic [1:0] MAX_MULT_SEL = 2'h1
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // link
  dram_cmd_if.dev link,
  // burst mode
  input wire logic i_otf_en,
  input wire logic i_bl32_default,
  // decoded command
  output logic o_cmd_valid,
  output cmd_kind_e o_cmd,
  output logic [2:0] o_bank,
  output logic o_all_banks,
  output logic o_auto_pre,
  output logic o_burst32,
  output logic [9:0] o_col,
  output logic [18:0] o_row,
  output logic [5:0] o_mr_addr,
  output logic [7:0] o_mr_op,
  output logic [7:0] o_pre_mask,
  // mode registers
  output logic [1:0] o_dec_reg,
  output logic [7:0] o_mgmt_reg
);
  localparam logic [7:0] MGMT_VAL = {MAX_MULT_SEL, INIT_THRESHOLD, MGMT_REQUIRED};
  dev_s q, d;
  cmd_kind_e cls;
  logic [5:0] ca;

  assign ca = link.ca;

  // first-edge opcode classification; unknown codes are reserved
  always_comb begin
    cls = K_NONE;
    if (ca[1:0] == `CA_ACT1) begin
      cls = K_ACT;
    end else begin
      case (ca[4:0])
        `CA_MPC: cls = K_MPC;
        `CA_PRE: cls = K_PRE;
        `CA_REF: cls = K_REF;
        `CA_SRE: cls = K_SRE;
        `CA_SRX: cls = K_SRX;
        `CA_WR1: cls = K_WR;
        `CA_MWR1: cls = K_MWR;
        `CA_RD1: cls = K_RD;
        `CA_MRR1: cls = K_MRR;
        `CA_CAS2: cls = K_CAS2;
        `CA_MRW1: cls = K_MRW;
        `CA_MRW2: cls = K_MRW2;
        default: cls = K_NONE;
      endcase
    end
  end

  // second edge completes what the first edge opened
  always_comb begin
    d = q;
    d.valid = 1'b0;
    d.pre_mask = 8'h00;
    d.mgmt = MGMT_VAL;
    case (q.st)
      D_IDLE: begin
        if (link.cs) begin
          d.f_ca = ca;
          // the edge after an activate first half is always its second
          d.f_kind = q.act_pend ? K_ACT : cls;
          d.st = D_SECOND;
        end
      end
      D_SECOND: begin
        d.st = D_IDLE;
        d.kind = q.f_kind;
        d.bank = ca[2:0];
        case (q.f_kind)
          K_PRE: begin
            d.valid = 1'b1;
            d.all = q.f_ca[5];
            d.pre_mask = q.f_ca[5] ? 8'hFF : 8'h01 << ca[2:0];
          end
          K_REF: begin
            d.valid = 1'b1;
            d.all = q.f_ca[5];
            // line 3 only counts while management is required
            if (MGMT_REQUIRED && ca[3]) begin
              d.kind = K_RFM;
              d.all = ca[5];
            end
          end
          K_SRE, K_SRX: d.valid = 1'b1;
          K_MPC: begin
            d.valid = 1'b1;
            d.mr_op = {1'b0, q.f_ca[5], ca};
          end
          K_WR, K_MWR, K_RD, K_MRR: begin
            d.col_pend = 1'b1;
            d.c_kind = q.f_kind;
            d.c_ba = ca[2:0];
            d.c_c9 = ca[4];
            d.c_ap = ca[5];
            d.c_bl = q.f_ca[5];
            if (q.f_kind == K_MRR) begin
              d.mr_addr = ca;
              d.c_ap = 1'b0;
            end
          end
          K_CAS2: begin
            // a stray column second half is dropped
            if (q.col_pend) begin
              d.col_pend = 1'b0;
              d.valid = 1'b1;
              d.kind = q.c_kind;
              d.bank = q.c_ba;
              d.ap = q.c_ap;
              d.col = {q.c_c9, q.f_ca[5], ca, 2'h0};
              d.b32 = (q.c_kind != K_MWR) && (i_otf_en ? q.c_bl : i_bl32_default);
              d.pre_mask = q.c_ap ? 8'h01 << q.c_ba : 8'h00;
            end
          end
          K_MRW: begin
            d.mrw_pend = 1'b1;
            d.mr_addr = ca;
            d.m_op7 = q.f_ca[5];
          end
          K_MRW2: begin
            if (q.mrw_pend) begin
              d.mrw_pend = 1'b0;
              d.valid = 1'b1;
              d.kind = K_MRW;
              d.mr_op = {q.m_op7, q.f_ca[5], ca};
              if (q.mr_addr == `MR_DEC_ADDR) begin
                d.dec_reg = ca[1:0];
              end
            end
          end
          K_ACT: begin
            if (!q.act_pend) begin
              d.act_pend = 1'b1;
              d.c_ba = ca[2:0];
              d.a_hi = {ca[3], q.f_ca[5:2], ca[5:4], 3'h0};
            end else begin
              d.act_pend = 1'b0;
              d.valid = 1'b1;
              d.bank = q.c_ba;
              d.row = {q.f_ca[1:0], q.a_hi[9:3], q.f_ca[5:2], ca};
            end
          end
          default: d.kind = K_NONE;
        endcase
      end
      default: d.st = D_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '{st: D_IDLE, f_kind: K_NONE, c_kind: K_NONE, kind: K_NONE,
        mgmt: MGMT_VAL, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_cmd_valid = q.valid;
  assign o_cmd = q.kind;
  assign o_bank = q.bank;
  assign o_all_banks = q.all;
  assign o_auto_pre = q.ap;
  assign o_burst32 = q.b32;
  assign o_col = q.col;
  assign o_row = q.row;
  assign o_mr_addr = q.mr_addr;
  assign o_mr_op = q.mr_op;
  assign o_pre_mask = q.pre_mask;
  assign o_dec_reg = q.dec_reg;
  assign o_mgmt_reg = q.mgmt;
endmodule : dram_dev_end

//--- tb/dram_cmd_refresh_mgmt_bench.sv
// self-checking bench: controller and device ends joined over the link
`timescale 1ns/100ps
`include "dram_cmd_map.svh"
module dram_cmd_refresh_mgmt_bench
  import dram_cmd_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  cmd_kind_e req_kind = K_NONE;
  logic [2:0] req_bank = 3'h0;
  logic req_all = 1'b0;
  logic req_ap = 1'b0;
  logic req_bl32 = 1'b0;
  logic [7:0] req_op = 8'h00;
  logic [9:0] req_col = 10'h2A7;
  logic [18:0] req_row = 19'h01234;
  logic [5:0] req_mr = 6'h24;
  logic otf_en = 1'b1;
  logic ready, refused, rfm_need, valid, all, b32, v2, all2, due, ap;
  logic [2:0] bank;
  logic [7:0] blocked, mgmt, pmask, pm_last, pm2, pm2_last;
  logic [1:0] dec;
  logic [9:0] col;
  logic [18:0] row;
  logic [6:0] w1;
  cmd_kind_e kind, k2;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_ref = 0;
  int n_v2 = 0;
  cmd_kind_e kinds[12] = '{K_WR, K_MWR, K_RD, K_MRR, K_MRW, K_PRE, K_REF, K_RFM,
    K_SRE, K_SRX, K_MPC, K_ACT};
  dram_cmd_if link_if();
  dram_cmd_if dut2_if();
  // ---------------------------------------------------------------
  // design ends and checker
  // ---------------------------------------------------------------
  dram_ctrl_end dram_ctrl_end_inst (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_req_valid(req_valid), .i_req_kind(req_kind), .i_req_bank(req_bank),
    .i_req_all(req_all), .i_req_ap(req_ap), .i_req_bl32(req_bl32), .i_req_col(req_col),
    .i_req_row(req_row), .i_req_mr_addr(req_mr), .i_req_op(req_op),
    .o_req_ready(ready), .o_req_refused(refused), .i_mgmt_reg(mgmt), .i_dec_reg(dec),
    .i_refresh_rate_mult(5'h01), .o_blocked(blocked), .o_refresh_due(due),
    .o_rfm_needed(rfm_need), .link(link_if.ctrl));
  dram_dev_end dram_dev_end_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .link(link_if.dev),
    .i_otf_en(otf_en), .i_bl32_default(1'b0), .o_cmd_valid(valid), .o_cmd(kind),
    .o_bank(bank), .o_all_banks(all), .o_auto_pre(ap), .o_burst32(b32), .o_col(col),
    .o_row(row), .o_mr_addr(), .o_mr_op(), .o_pre_mask(pmask), .o_dec_reg(dec),
    .o_mgmt_reg(mgmt));
  // second device end is driven by the bench to break the pairing on purpose
  dram_dev_end dev2_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .link(dut2_if.dev),
    .i_otf_en(1'b1), .i_bl32_default(1'b0), .o_cmd_valid(v2), .o_cmd(k2), .o_bank(),
    .o_all_banks(all2), .o_auto_pre(), .o_burst32(), .o_col(), .o_row(),
    .o_mr_addr(), .o_mr_op(), .o_pre_mask(pm2), .o_dec_reg(), .o_mgmt_reg());
  dram_link_checker #(.USE_UPPER_ROW(1'b0)) dram_link_checker_inst (.i_ref_clk(clk),
    .i_arst_n(rst_n), .cs(link_if.cs), .ca(link_if.ca));
  always #2 clk = ~clk;
  // pulses are latched here since tasks look only after the sequence ends
  always @(negedge clk) begin
    if (refused === 1'b1) n_ref <= n_ref + 1;
    if (v2 === 1'b1) n_v2 <= n_v2 + 1;
    if (pmask !== 8'h00) pm_last <= pmask;
    if (pm2 !== 8'h00) pm2_last <= pm2;
  end
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until the edge that takes it, then waits for ready again
  task automatic send(input cmd_kind_e k, input logic [2:0] b, input logic a);
    req_valid <= 1'b1;
    req_kind <= k;
    req_bank <= b;
    req_all <= a;
    req_ap <= (k == K_WR);
    req_bl32 <= (k != K_MWR);
    // ready is looked at between edges, never in the step that updates it
    repeat (600) begin
      @(negedge clk);
      if (ready === 1'b1) break;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    w1 = {link_if.cs, link_if.ca};
    repeat (600) begin
      if (ready === 1'b1) break;
      @(negedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : send
  task automatic act_n(input logic [2:0] b, input int n);
    repeat (n) send(K_ACT, b, 1'b0);
  endtask : act_n
  // one command on the second link; the released bus shows the inverse
  task automatic cmd2(input logic [5:0] f, input logic [5:0] s);
    dut2_if.cs <= 1'b1;
    dut2_if.ca <= f;
    @(posedge clk);
    dut2_if.cs <= 1'b0;
    dut2_if.ca <= s;
    @(posedge clk);
    dut2_if.ca <= ~s;
    repeat (3) @(posedge clk);
  endtask : cmd2
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // watchdog sized well above the longest sequence of requests
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    dut2_if.cs = 1'b0;
    dut2_if.ca = 6'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(mgmt, {2'h1, 5'h10, 1'b1});
    chk(rfm_need, 1'b0);
    foreach (kinds[i]) begin
      send(kinds[i], 3'h3, 1'b0);
      chk(kind, kinds[i]);
      case (kinds[i])
        K_WR: begin
          chk(col, 10'h2A0);
          chk(pm_last, 8'h08);
          chk(ap, 1'b1);
          chk(bank, 3'h3);
          chk(b32, 1'b1);
          chk(w1, 7'h64);
        end
        K_MWR: chk(w1, 7'h4C);
        K_RD: chk(col, 10'h2A4);
        K_ACT: chk(row, 19'h61234);
        default: ;
      endcase
    end
    send(K_PRE, 3'h0, 1'b1);
    chk(pm_last, 8'hFF);
    chk(all, 1'b1);
    otf_en <= 1'b0; // fixed burst length ignores the select
    send(K_RD, 3'h1, 1'b0);
    chk(b32, 1'b0);
    $display("test command kinds done");
    act_n(3'h5, 64);
    chk(blocked, 8'h20);
    chk(rfm_need, 1'b1);
    send(K_ACT, 3'h5, 1'b0);
    chk(n_ref, 1);
    send(K_RFM, 3'h0, 1'b1);
    chk(blocked, 8'h00);
    act_n(3'h5, 16);
    chk(blocked, 8'h20);
    send(K_SRE, 3'h0, 1'b0);
    send(K_SRX, 3'h0, 1'b0);
    chk(blocked, 8'h20);
    send(K_REF, 3'h5, 1'b0);
    chk(due, 1'b0);
    act_n(3'h5, 15);
    chk(blocked, 8'h00);
    repeat (1000) @(posedge clk);
    chk(due, 1'b1);
    act_n(3'h3, 63);
    chk(blocked, 8'h00);
    act_n(3'h3, 1);
    chk(blocked, 8'h08);
    $display("test tallies done");
    req_op <= 8'h02;
    send(K_MRW, 3'h0, 1'b0);
    chk(dec, 2'h2);
    send(K_RFM, 3'h3, 1'b0);
    act_n(3'h3, 31);
    chk(blocked, 8'h00);
    act_n(3'h3, 1);
    chk(blocked, 8'h08);
    $display("test decrement done");
    cmd2({1'b0, `CA_CAS2}, 6'h15);
    chk(n_v2, 0);
    cmd2({1'b1, `CA_REF}, 6'h2D);
    chk(k2, K_RFM);
    chk(all2, 1'b1);
    cmd2({1'b0, `CA_REF}, 6'h05);
    chk(k2, K_REF);
    cmd2({1'b0, `CA_PRE}, 6'h06);
    chk(pm2_last, 8'h40);
    $display("test device decode done");
    final_report();
  end
endmodule : dram_cmd_refresh_mgmt_bench

//--- tb/dram_link_checker.sv
// checker for the command link between the controller and device ends
`timescale 1ns/100ps
`include "dram_cmd_map.svh"
module dram_link_checker #(
  parameter bit USE_UPPER_ROW = 1'b0
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // link
  input wire logic cs,
  input wire logic [5:0] ca
);
  logic act_pend_q;
  logic col1;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // ---------------------------------------------------------------
  // open activate pair
  // ---------------------------------------------------------------
  // an activate second word can mimic any first word, so it is masked out
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      act_pend_q <= 1'b0;
    end else if (cs) begin
      act_pend_q <= !act_pend_q && ca[1:0] == `CA_ACT1;
    end
  end
  // column first halves that need a column second half
  assign col1 = cs && !act_pend_q && ca[4:0] inside {`CA_WR1, `CA_MWR1, `CA_RD1, `CA_MRR1};
  a_cmd_two_cycles: assert property (cs |=> !cs)
    else $error("command word not followed by its second cycle");
  a_mwr_line5_low: assert property (cs && !act_pend_q && ca[4:0] == `CA_MWR1 |-> !ca[5])
    else $error("masked write first edge with line 5 high");
  a_col_second_half: assert property (col1 |-> ##2 cs && ca[4:0] == `CA_CAS2)
    else $error("column first half not followed by column second half");
  a_write_col_low: assert property (col1 && ca[4:0] inside {`CA_WR1, `CA_MWR1}
      |-> ##3 ca[1:0] == 2'b00)
    else $error("write column bits 3:2 not driven low");
  a_mpc_pause: assert property (cs && !act_pend_q && ca[4:0] == `CA_MPC
      |-> ##2 (cs && ca[4:0] == `CA_CAS2) or (!cs ##1 !cs))
    else $error("multi purpose command without two deselects");
  a_act_pair: assert property (cs && !act_pend_q && ca[1:0] == `CA_ACT1
      |-> ##2 cs && act_pend_q)
    else $error("activate first half not followed by second half");
  a_mrw_pair: assert property (cs && !act_pend_q && ca[4:0] == `CA_MRW1
      |-> ##2 cs && ca[4:0] == `CA_MRW2)
    else $error("mode write first half not followed by second half");
  a_upper_row_high: assert property (cs && act_pend_q && !USE_UPPER_ROW
      |-> ca[1:0] == 2'b11)
    else $error("unused upper row bits not driven high");
  c_activate: cover property (cs && !act_pend_q && ca[1:0] == `CA_ACT1);
  c_column: cover property (col1);
  c_mpc: cover property (cs && !act_pend_q && ca[4:0] == `CA_MPC);
endmodule : dram_link_checker
